/* rtl/lec_ctrl.sv */
// Per-channel error counter, error inject and alarm indication control.
// Assumes all inputs synchronous to clk_i; pulse inputs are one cycle wide.
module lec_ctrl #(
   parameter int SECOND_CYC = lec_pkg::LEC_SECOND_CYC
) (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire lec_pkg::lec_req_t req_i,
   output logic [7:0] rdata_o,
   input wire lec_pkg::lec_evt_t evt_i,
   input wire logic tx_pulse_i,
   input wire logic tx_above_thr_i,
   input wire logic tx_mark_i,
   input wire logic pat_bit_i,
   input wire logic pat_valid_i,
   input wire logic system_side_signal_absent_i,
   input wire logic line_side_signal_absent_i,
   input wire logic rx_data_i,
   input wire logic tx_data_i,
   output logic transmit_signal_absent_o,
   output logic zeros_standard_sel_o,
   output logic violation_place_o,
   output logic pat_bit_o,
   output logic rx_data_o,
   output logic tx_data_o,
   output logic rx_alarm_o,
   output logic tx_alarm_o,
   output logic irq_o
);
   logic [7:0] fault_q;
   logic [7:0] alarm_q;
   logic [1:0] period_q;
   logic [15:0] count_q;
   logic [15:0] result_q;
   logic [7:0] stat_q;
   logic [7:0] stat_set;
   logic [7:0] mask_q;
   logic [6:0] low_cnt_q;
   logic [6:0] abs_limit;
   logic abs_q;
   logic latch_prev_q;
   logic finj_prev_q;
   logic finj_arm_q;
   logic [26:0] sec_q;
   logic sec_tick;
   logic latch_now;
   logic count_evt;
   logic wr_fault;
   logic wr_alarm;
   logic vplace;
   logic fdone;
   logic rx_alarm;
   logic tx_alarm;
   lec_pkg::lec_src_t src;

   assign wr_fault = req_i.wr && (req_i.addr == lec_pkg::LEC_ADDR_FAULT);
   assign wr_alarm = req_i.wr && (req_i.addr == lec_pkg::LEC_ADDR_ALARM);
   assign src = lec_pkg::lec_src_t'(fault_q[lec_pkg::LEC_B_SRC_HI:lec_pkg::LEC_B_SRC_LO]);
   assign zeros_standard_sel_o = fault_q[lec_pkg::LEC_B_ZSTD];

   // Violation is placed on the first mark while the inject bit is set
   assign vplace = fault_q[lec_pkg::LEC_B_VINJ] && tx_mark_i;
   assign violation_place_o = vplace;
   // Pattern flip lands on the next valid pattern bit after a rising edge
   assign fdone = finj_arm_q && pat_valid_i;

   // Control register; self-clearing inject bits, hardware clear wins only
   // when no fresh write of one arrives in the same cycle
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         fault_q <= lec_pkg::LEC_RST_FAULT;
      end else if (wr_fault) begin
         fault_q <= req_i.wdata;
      end else begin
         if (vplace) begin
            fault_q[lec_pkg::LEC_B_VINJ] <= 1'b0;
         end
         if (fdone) begin
            fault_q[lec_pkg::LEC_B_FINJ] <= 1'b0;
         end
      end
   end

   // Alarm generation, period select and mask registers
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         alarm_q <= lec_pkg::LEC_RST_ALARM;
         period_q <= lec_pkg::LEC_RST_PERIOD;
         mask_q <= lec_pkg::LEC_RST_MASK;
      end else if (req_i.wr) begin
         if (wr_alarm) begin
            alarm_q <= {4'h0, req_i.wdata[3:0]};
         end
         if (req_i.addr == lec_pkg::LEC_ADDR_PERIOD) begin
            period_q <= req_i.wdata[1:0];
         end
         if (req_i.addr == lec_pkg::LEC_ADDR_MASK) begin
            mask_q <= req_i.wdata;
         end
      end
   end

   // Edge trackers for the pattern flip request
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         finj_prev_q <= 1'b0;
         finj_arm_q <= 1'b0;
      end else begin
         finj_prev_q <= fault_q[lec_pkg::LEC_B_FINJ];
         if (fault_q[lec_pkg::LEC_B_FINJ] && !finj_prev_q) begin
            finj_arm_q <= 1'b1;
         end else if (fdone) begin
            finj_arm_q <= 1'b0;
         end
      end
   end

   // Pattern output with the single flipped bit
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         pat_bit_o <= 1'b0;
      end else begin
         pat_bit_o <= pat_bit_i ^ fdone;
      end
   end

   // Absence limit from the period select; code 1X means 64
   always_comb begin
      unique case (period_q)
         2'h0: abs_limit = lec_pkg::LEC_ABS_16;
         2'h1: abs_limit = lec_pkg::LEC_ABS_32;
         default: abs_limit = lec_pkg::LEC_ABS_64;
      endcase
   end

   // Count low pulses; any pulse above threshold clears at once
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         low_cnt_q <= 7'h00;
         abs_q <= 1'b0;
      end else if (tx_pulse_i && tx_above_thr_i) begin
         low_cnt_q <= 7'h00;
         abs_q <= 1'b0;
      end else if (tx_pulse_i) begin
         if (low_cnt_q + 7'h01 >= abs_limit) begin
            abs_q <= 1'b1;
         end
         if (low_cnt_q < lec_pkg::LEC_ABS_64) begin
            low_cnt_q <= low_cnt_q + 7'h01;
         end
      end
   end
   assign transmit_signal_absent_o = abs_q;

   // Event selection for the error counter
   always_comb begin
      unique case (src)
         lec_pkg::LEC_SRC_OFF: count_evt = 1'b0;
         lec_pkg::LEC_SRC_LV: count_evt = evt_i.line_side_violation;
         lec_pkg::LEC_SRC_LZ: count_evt = evt_i.line_side_excess_zeros;
         lec_pkg::LEC_SRC_LB: count_evt = evt_i.line_side_violation
                                      | evt_i.line_side_excess_zeros;
         lec_pkg::LEC_SRC_SV: count_evt = evt_i.system_side_violation;
         lec_pkg::LEC_SRC_SZ: count_evt = evt_i.system_side_excess_zeros;
         lec_pkg::LEC_SRC_SB: count_evt = evt_i.system_side_violation
                                      | evt_i.system_side_excess_zeros;
         lec_pkg::LEC_SRC_PAT: count_evt = evt_i.pattern_error;
      endcase
   end

   // One-second timer, only running in automatic mode
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         sec_q <= 27'h0000000;
      end else if (!fault_q[lec_pkg::LEC_B_MODE] || sec_tick) begin
         sec_q <= 27'h0000000;
      end else begin
         sec_q <= sec_q + 27'h0000001;
      end
   end
   assign sec_tick = fault_q[lec_pkg::LEC_B_MODE]
                     && (sec_q == 27'(SECOND_CYC - 1));

   // Manual latch edge, ignored in automatic mode; software must clear
   // the bit before another edge can be seen
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         latch_prev_q <= 1'b0;
      end else begin
         latch_prev_q <= fault_q[lec_pkg::LEC_B_LATCH];
      end
   end
   assign latch_now = fault_q[lec_pkg::LEC_B_MODE] ? sec_tick
                    : (fault_q[lec_pkg::LEC_B_LATCH] && !latch_prev_q);

   // Error counter saturates so a long interval never wraps to a small value
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         count_q <= 16'h0000;
         result_q <= 16'h0000;
      end else if (latch_now) begin
         result_q <= count_q;
         count_q <= {15'h0000, count_evt};
      end else if (count_evt && count_q != 16'hFFFF) begin
         count_q <= count_q + 16'h0001;
      end
   end

   // Alarm substitution with all ones while the enabled absence lasts
   assign rx_alarm = (alarm_q[lec_pkg::LEC_B_RX_SYS] && system_side_signal_absent_i)
                   || (alarm_q[lec_pkg::LEC_B_RX_LINE] && line_side_signal_absent_i);
   assign tx_alarm = (alarm_q[lec_pkg::LEC_B_TX_SYS] && system_side_signal_absent_i)
                   || (alarm_q[lec_pkg::LEC_B_TX_LINE] && line_side_signal_absent_i);
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rx_data_o <= 1'b0;
         tx_data_o <= 1'b0;
         rx_alarm_o <= 1'b0;
         tx_alarm_o <= 1'b0;
      end else begin
         rx_data_o <= rx_alarm | rx_data_i;
         tx_data_o <= tx_alarm | tx_data_i;
         rx_alarm_o <= rx_alarm;
         tx_alarm_o <= tx_alarm;
      end
   end

   // Sticky status; a new event wins over a write-one clear
   always_comb begin
      stat_set = 8'h00;
      stat_set[lec_pkg::LEC_S_TXABS] = abs_q;
      stat_set[lec_pkg::LEC_S_LATCH] = latch_now;
      stat_set[lec_pkg::LEC_S_VDONE] = vplace;
      stat_set[lec_pkg::LEC_S_FDONE] = fdone;
      stat_set[lec_pkg::LEC_S_OVF] = count_evt && (count_q == 16'hFFFF) && !latch_now;
   end
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         stat_q <= 8'h00;
      end else if (req_i.wr && req_i.addr == lec_pkg::LEC_ADDR_STAT) begin
         stat_q <= (stat_q & ~req_i.wdata) | stat_set;
      end else begin
         stat_q <= stat_q | stat_set;
      end
   end
   assign irq_o = |(stat_q & mask_q);

   // Read data one cycle after the strobe, zero otherwise and when unmapped
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rdata_o <= 8'h00;
      end else if (req_i.rd) begin
         unique case (req_i.addr)
            lec_pkg::LEC_ADDR_FAULT: rdata_o <= fault_q;
            lec_pkg::LEC_ADDR_ALARM: rdata_o <= alarm_q;
            lec_pkg::LEC_ADDR_PERIOD: rdata_o <= {6'h00, period_q};
            lec_pkg::LEC_ADDR_RESH: rdata_o <= result_q[15:8];
            lec_pkg::LEC_ADDR_RESL: rdata_o <= result_q[7:0];
            lec_pkg::LEC_ADDR_STAT: rdata_o <= stat_q;
            lec_pkg::LEC_ADDR_MASK: rdata_o <= mask_q;
            lec_pkg::LEC_ADDR_LIVE: rdata_o <= {5'h00, tx_alarm, rx_alarm, abs_q};
            default: rdata_o <= 8'h00;
         endcase
      end else begin
         rdata_o <= 8'h00;
      end
   end
endmodule

/* inc/lec_pkg.sv */
// Constants, field layouts and carrier structs for the per-channel error count and AIS block.
// Assumes one 125 MHz clock; every line-side event input is a one-cycle pulse on that clock.
// What this block does
// - Transmit signal absent declared after 16, 32 or 64 low pulses per period select.
// - Bit 7 selects excessive-zeros standard: 0 ANSI, 1 FCC.
// - Writing one to bit 6 places one violation on the next transmit mark.
// - The violation inject bit clears itself once the violation was placed.
// - Rising edge of bit 5 flips one bit of the generated test pattern.
// - The pattern flip inject bit clears itself once the flip was made.
// - Bits 4..2 pick counted events: off, line, system or pattern error sources.
// - Bit 1 picks manual latching (0) or automatic latching every second (1).
// - The manual latch bit acts only in manual mode, ignored in automatic mode.
// - In manual mode a rising manual latch bit copies the count to the results.
// - Alarm bit 3 sends all-ones into receive path on system-side absence.
// - Alarm bit 2 sends all-ones into receive path on line-side absence.
// - Alarm bit 1 sends all-ones into transmit path on system-side absence.
// - Alarm bit 0 sends all-ones into transmit path on line-side absence.
// - Transmit signal absent clears as soon as a pulse is above threshold.
package lec_pkg;
   // Register offsets (byte addresses on the plain port)
   localparam logic [7:0] LEC_ADDR_FAULT = 8'h0E; // fault_count_inject_ctrl
   localparam logic [7:0] LEC_ADDR_ALARM = 8'h0F; // alarm_indication_gen_ctrl
   localparam logic [7:0] LEC_ADDR_PERIOD = 8'h10; // tx_absent_period_sel
   localparam logic [7:0] LEC_ADDR_RESH = 8'h11; // count_result_high
   localparam logic [7:0] LEC_ADDR_RESL = 8'h12; // count_result_low
   localparam logic [7:0] LEC_ADDR_STAT = 8'h13; // status, write one to clear
   localparam logic [7:0] LEC_ADDR_MASK = 8'h14; // interrupt mask
   localparam logic [7:0] LEC_ADDR_LIVE = 8'h15; // live condition flags
   // Reset values
   localparam logic [7:0] LEC_RST_FAULT = 8'h00;
   localparam logic [7:0] LEC_RST_ALARM = 8'h00;
   localparam logic [1:0] LEC_RST_PERIOD = 2'h1;
   localparam logic [7:0] LEC_RST_MASK = 8'h00;
   // Field positions of fault_count_inject_ctrl
   localparam int LEC_B_ZSTD = 7;
   localparam int LEC_B_VINJ = 6;
   localparam int LEC_B_FINJ = 5;
   localparam int LEC_B_SRC_HI = 4;
   localparam int LEC_B_SRC_LO = 2;
   localparam int LEC_B_MODE = 1;
   localparam int LEC_B_LATCH = 0;
   // Field positions of alarm_indication_gen_ctrl
   localparam int LEC_B_RX_SYS = 3;
   localparam int LEC_B_RX_LINE = 2;
   localparam int LEC_B_TX_SYS = 1;
   localparam int LEC_B_TX_LINE = 0;
   // Status bit positions
   localparam int LEC_S_TXABS = 0;
   localparam int LEC_S_LATCH = 1;
   localparam int LEC_S_VDONE = 2;
   localparam int LEC_S_FDONE = 3;
   localparam int LEC_S_OVF = 4;
   // Pulse counts for signal absence
   localparam logic [6:0] LEC_ABS_16 = 7'h10;
   localparam logic [6:0] LEC_ABS_32 = 7'h20;
   localparam logic [6:0] LEC_ABS_64 = 7'h40;
   // One second of clock cycles at 125 MHz
   localparam int LEC_CLK_HZ = 125000000;
   localparam int LEC_SECOND_S = 1;
   localparam int LEC_SECOND_CYC = LEC_CLK_HZ * LEC_SECOND_S;
   // Counter source codes
   typedef enum logic [2:0] {
      LEC_SRC_OFF = 3'h0,
      LEC_SRC_LV = 3'h1,
      LEC_SRC_LZ = 3'h2,
      LEC_SRC_LB = 3'h3,
      LEC_SRC_SV = 3'h4,
      LEC_SRC_SZ = 3'h5,
      LEC_SRC_SB = 3'h6,
      LEC_SRC_PAT = 3'h7
   } lec_src_t;
   // Register port request
   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } lec_req_t;
   // Error events, each a one-cycle pulse
   typedef struct packed {
      logic line_side_violation;
      logic line_side_excess_zeros;
      logic system_side_violation;
      logic system_side_excess_zeros;
      logic pattern_error;
   } lec_evt_t;
endpackage

/* test/lec_ctrl_sva.sv */
// Port-level properties of the inject, absence and alarm logic of lec_ctrl.
// Assumes it is bound to every lec_ctrl instance and sees only its ports.
module lec_ctrl_sva (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire lec_pkg::lec_req_t req_i,
   input wire logic [7:0] rdata_o,
   input wire lec_pkg::lec_evt_t evt_i,
   input wire logic tx_pulse_i,
   input wire logic tx_above_thr_i,
   input wire logic tx_mark_i,
   input wire logic pat_bit_i,
   input wire logic pat_valid_i,
   input wire logic system_side_signal_absent_i,
   input wire logic line_side_signal_absent_i,
   input wire logic rx_data_i,
   input wire logic tx_data_i,
   input wire logic transmit_signal_absent_o,
   input wire logic zeros_standard_sel_o,
   input wire logic violation_place_o,
   input wire logic pat_bit_o,
   input wire logic rx_data_o,
   input wire logic tx_data_o,
   input wire logic rx_alarm_o,
   input wire logic tx_alarm_o,
   input wire logic irq_o
);
   timeunit 1ns;
   timeprecision 1ps;
   // One domain, so clock and reset are given once
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (!rst_n_i);
   a_viol_on_mark: assert property (violation_place_o |-> tx_mark_i)
      else $error("violation placed off a mark");
   a_viol_once: assert property (violation_place_o |=> !violation_place_o)
      else $error("violation placed twice");
   a_zstd_write: assert property (req_i.wr && req_i.addr == lec_pkg::LEC_ADDR_FAULT
      |=> zeros_standard_sel_o == $past(req_i.wdata[7])) else $error("zeros std stale");
   a_abs_clear: assert property (tx_pulse_i && tx_above_thr_i
      |=> !transmit_signal_absent_o) else $error("absence not cleared");
   a_rx_alarm_cause: assert property (rx_alarm_o
      |-> $past(system_side_signal_absent_i || line_side_signal_absent_i))
      else $error("rx alarm without absence");
   a_tx_alarm_cause: assert property (tx_alarm_o
      |-> $past(system_side_signal_absent_i || line_side_signal_absent_i))
      else $error("tx alarm without absence");
   a_rx_all_ones: assert property (rx_alarm_o |-> rx_data_o)
      else $error("rx data not forced high");
   a_tx_all_ones: assert property (tx_alarm_o |-> tx_data_o)
      else $error("tx data not forced high");
   // Guarded so the flop's reset value is not taken for a flip
   a_flip_cause: assert property ($past(rst_n_i) && pat_bit_o != $past(pat_bit_i)
      |-> $past(pat_valid_i)) else $error("pattern flipped without a bit");
   c_viol: cover property (violation_place_o);
   c_alarms: cover property (rx_alarm_o && tx_alarm_o);
   c_absent: cover property (transmit_signal_absent_o);
   c_irq: cover property (irq_o);
endmodule

bind lec_ctrl lec_ctrl_sva u_sva (.*);

/* test/tb_top.sv */
// Self-checking bench for lec_ctrl: registers, counter, injects, absence and alarms.
// Assumes a 125 MHz clock and a shortened one-second count.
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int SEC = 100;
   logic clk_i = 1'h0;
   logic rst_n_i = 1'h0;
   lec_pkg::lec_req_t req_i = '0;
   lec_pkg::lec_evt_t evt_i = '0;
   logic tx_pulse_i = 1'h0, tx_above_thr_i = 1'h0, tx_mark_i = 1'h0;
   logic pat_bit_i = 1'h0, pat_valid_i = 1'h0, rx_data_i = 1'h0, tx_data_i = 1'h0;
   logic system_side_signal_absent_i = 1'h0, line_side_signal_absent_i = 1'h0;
   logic [7:0] rdata_o;
   logic transmit_signal_absent_o, zeros_standard_sel_o, violation_place_o, pat_bit_o;
   logic rx_data_o, tx_data_o, rx_alarm_o, tx_alarm_o, irq_o;
   int errors = 0;
   int n_compared = 0;
   integer seed = 32'h15789F2F;
   // Event classes counted by each source code, one bit per event
   int msk[8] = '{0, 1, 2, 3, 4, 8, 12, 16};
   lec_ctrl #(.SECOND_CYC(SEC)) uut (.*);
   initial begin
      forever #4 clk_i = ~clk_i;
   end
   task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
      n_compared++;
      if (g !== e) begin
         errors++;
         $display("FAIL %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge clk_i);
      #1;
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_i);
      req_i.addr <= a;
      req_i.wdata <= d;
      req_i.wr <= 1'h1;
      @(posedge clk_i);
      req_i.wr <= 1'h0;
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge clk_i);
      req_i.addr <= a;
      req_i.rd <= 1'h1;
      @(posedge clk_i);
      req_i.rd <= 1'h0;
      #1 d = rdata_o;
   endtask
   task automatic rchk(input string nm, input logic [7:0] a, input logic [7:0] e);
      logic [7:0] d;
      rd(a, d);
      chk(nm, e, d);
   endtask
   // Pulse ends with the edge that samples it, so the result is already registered
   task automatic pulse(input logic a);
      @(posedge clk_i);
      tx_pulse_i <= 1'h1;
      tx_above_thr_i <= a;
      @(posedge clk_i);
      tx_pulse_i <= 1'h0;
      #1;
   endtask
   task automatic report_and_stop;
      $display("compared %0d errors %0d", n_compared, errors);
      if (errors == 0 && n_compared > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   initial begin
      int cnt, ev, n;
      logic [7:0] hi, lo;
      logic b, d;
      logic [7:0] lv;
      repeat (20) @(posedge clk_i);
      rst_n_i <= 1'h1;
      rchk("fault reset", 8'h0E, 8'h00);
      rchk("alarm reset", 8'h0F, 8'h00);
      rchk("period reset", 8'h10, 8'h01);
      rchk("unmapped", 8'h3C, 8'h00);
      wr(8'h0E, 8'h80);
      tick(2);
      chk("zeros std", 1, zeros_standard_sel_o);
      // Every source code, events kept away from the latch edge
      for (int s = 0; s < 8; s++) begin
         cnt = 0;
         wr(8'h0E, 8'(s << 2));
         repeat (24) begin
            ev = {$random(seed)} % 6;
            @(posedge clk_i);
            evt_i <= lec_pkg::lec_evt_t'(5'h10 >> ev);
            cnt += (msk[s] >> ev) & 1;
         end
         @(posedge clk_i);
         evt_i <= '0;
         wr(8'h0E, 8'(s << 2 | 1));
         tick(2);
         rd(8'h11, hi);
         rd(8'h12, lo);
         chk("count", 16'(cnt), {hi, lo});
         wr(8'h0E, 8'(s << 2));
      end
      wr(8'h0E, 8'h40);
      tick(3);
      chk("no mark", 0, violation_place_o);
      @(posedge clk_i);
      tx_mark_i <= 1'h1;
      #1 chk("place", 1, violation_place_o);
      @(posedge clk_i);
      #1 chk("once", 0, violation_place_o);
      @(posedge clk_i);
      tx_mark_i <= 1'h0;
      rchk("inject clear", 8'h0E, 8'h00);
      wr(8'h0E, 8'h20);
      tick(3);
      @(posedge clk_i);
      pat_valid_i <= 1'h1;
      @(posedge clk_i);
      pat_valid_i <= 1'h0;
      #1 chk("flip", 1, pat_bit_o);
      // A second pattern bit must pass untouched once the request is spent
      @(posedge clk_i);
      pat_valid_i <= 1'h1;
      @(posedge clk_i);
      pat_valid_i <= 1'h0;
      #1 chk("flip single", 0, pat_bit_o);
      rchk("flip clear", 8'h0E, 8'h00);
      for (int p = 0; p < 4; p++) begin
         n = 16 << (p > 1 ? 2 : p);
         wr(8'h10, 8'(p));
         pulse(1'h1);
         repeat (n - 1) pulse(1'h0);
         chk("not yet", 0, transmit_signal_absent_o);
         pulse(1'h0);
         chk("absent", 1, transmit_signal_absent_o);
         pulse(1'h1);
         chk("absent clear", 0, transmit_signal_absent_o);
      end
      for (int k = 0; k < 64; k++) begin
         wr(8'h0F, 8'(k & 15));
         d = 1'($random(seed));
         @(posedge clk_i);
         system_side_signal_absent_i <= k[4];
         line_side_signal_absent_i <= k[5];
         rx_data_i <= d;
         tx_data_i <= !d;
         tick(3);
         b = k[3] & k[4] | k[2] & k[5];
         chk("rx alarm", b, rx_alarm_o);
         lv = {6'h00, b, 1'h0};
         chk("rx data", b | d, rx_data_o);
         b = k[1] & k[4] | k[0] & k[5];
         chk("tx alarm", b, tx_alarm_o);
         chk("tx data", b | !d, tx_data_o);
         lv[2] = b;
         rchk("live", 8'h15, lv);
      end
      wr(8'h13, 8'hFF);
      wr(8'h14, 8'h02);
      tick(2);
      chk("irq idle", 0, irq_o);
      wr(8'h0E, 8'h02);
      n = 0;
      while (irq_o !== 1'h1 && n < 3 * SEC) begin
         tick(1);
         n++;
      end
      chk("auto latch", 1, irq_o);
      if (n == 3 * SEC) begin
         report_and_stop();
      end
      chk("second period", SEC, n);
      rchk("status latch", 8'h13, 8'h02);
      rchk("mask", 8'h14, 8'h02);
      wr(8'h14, 8'h00);
      tick(1);
      chk("irq masked", 0, irq_o);
      wr(8'h0E, 8'h00);
      wr(8'h13, 8'h02);
      wr(8'h14, 8'h02);
      tick(2);
      chk("irq cleared", 0, irq_o);
      // Latch requests are ignored in automatic mode and leave no edge behind
      wr(8'h0E, 8'h02);
      wr(8'h0E, 8'h03);
      wr(8'h0E, 8'h01);
      tick(2);
      rchk("latch ignored", 8'h13, 8'h00);
      report_and_stop();
   end
endmodule
